// *** include/oamc_pkg.sv ***
// Constants and carrier types of the output actuation mode controller
package oamc_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned FREQ_BASE_KHZ = 10;
  localparam int unsigned FREQ_STEP_KHZ = 2;
  localparam int unsigned FREQ_MAX_KHZ = 24;
  localparam logic [2:0] FREQ_MAX_CODE = 3'h7;
  localparam int unsigned DEAD_TIME_MS = 6;
  localparam int unsigned DEAD_TIME_CYC = CLK_HZ / 1000 * DEAD_TIME_MS;
  localparam int unsigned DS_DELAY_MS = 1;
  localparam int unsigned DS_DELAY_CYC = CLK_HZ / 1000 * DS_DELAY_MS;
  localparam logic [7:0] DS_THRESH_RST = 8'h0A; // 1 V in 100 mV steps
  localparam int unsigned EN_FILT_CYC = 500; // Enable edge filter, 10 us
  localparam logic [1:0] CRASH_ON = 2'h2; // bits (1, 0)
  localparam int unsigned TMR_W = 32;
  localparam int unsigned N_OUT = 6;
  localparam int unsigned N_EXT = 2;
  localparam logic [7:0] CUR_RST = 8'h00;

  typedef enum logic [1:0] {
    OAMC_SLEEP = 2'b00,
    OAMC_STANDBY = 2'b01,
    OAMC_NORMAL = 2'b10,
    OAMC_CRASH = 2'b11
  } oamc_mode_t;

  typedef enum logic [1:0] {
    OAMC_IDLE = 2'b00,
    OAMC_ON = 2'b01,
    OAMC_OFF = 2'b10
  } oamc_act_t;

  // Per-output programmed settings
  typedef struct packed {
    logic [7:0] cur;
    logic [7:0] duty;
    logic cur_mode;
  } oamc_chan_t;

  // Supply and pump levels from the analog side
  typedef struct packed {
    logic io_above_sleep;
    logic io_above_uv;
    logic core_above_rst;
    logic pump_above_low;
    logic supplies_stable;
  } oamc_supply_t;
endpackage

// *** verilog/oamc_pin_filter.sv ***
// Two-flop synchroniser with rising edge stable-time filter
`timescale 1ns/100ps
module oamc_pin_filter #(
  parameter int unsigned FILT_CYC = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic sync1;
  logic sync2;
  logic [15:0] cnt;

  // Two-flop synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
    end
  end

  // High must persist for the filter time; low acts at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 16'h0000;
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      rise <= 1'b0;
      if (!sync2) begin
        cnt <= 16'h0000;
        level <= 1'b0;
      end else if (!level) begin
        if (cnt >= 16'(FILT_CYC - 1)) begin
          level <= 1'b1;
          rise <= 1'b1;
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end
    end
  end
endmodule

// *** verilog/oamc_ctrl.sv ***
// Mode state machine, actuation sequencer and output supervision
`timescale 1ns/100ps
module oamc_ctrl #(
  parameter int unsigned EN_FILT_CYC = oamc_pkg::EN_FILT_CYC,
  parameter int unsigned DEAD_CYC = oamc_pkg::DEAD_TIME_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en_out_pin,
  input wire logic csn_pin,
  input wire oamc_pkg::oamc_supply_t supply,
  input wire logic [2:0] pwm_freq_sel,
  input wire logic [1:0] crash_override_sel,
  input wire logic start_cmd,
  input wire logic standby_req_a,
  input wire logic standby_req_b,
  input wire logic [oamc_pkg::TMR_W-1:0] on_time_cyc,
  input wire logic [oamc_pkg::TMR_W-1:0] off_time_cyc,
  input wire logic [7:0] ds_thresh,
  input wire logic [oamc_pkg::TMR_W-1:0] ds_delay_cyc,
  input wire logic [1:0] ds_over,
  input wire logic [1:0] ds_fault_clr,
  input wire logic [5:0] oc_det,
  input wire logic fault_pin_sel,
  input wire logic group_a,
  input wire logic group_b,
  input wire oamc_pkg::oamc_chan_t [5:0] chan,
  input wire logic pump_low_clr,
  output oamc_pkg::oamc_mode_t mode,
  output logic [4:0] freq_khz,
  output logic [5:0] out_on,
  output logic [5:0] oc_latched,
  output logic [1:0] ext_hs_on,
  output logic [1:0] ext_ls_on,
  output logic [1:0] ds_fault,
  output logic global_fault,
  output logic fault_pin,
  output logic pump_low_flag,
  output logic sdo_low,
  output logic cfg_reset,
  output logic [7:0] ds_thresh_act,
  output logic [9:0] grp_cur_a,
  output logic [9:0] grp_cur_b,
  output logic [7:0] duty_a,
  output logic [7:0] duty_b,
  output oamc_pkg::oamc_act_t act_state
);
  logic en_level;
  logic en_rise;
  logic csn_s1;
  logic csn_s2;
  logic pump_ok;
  logic act_start;
  logic act_abort;
  logic [oamc_pkg::TMR_W-1:0] act_cnt;
  logic [oamc_pkg::TMR_W-1:0] dt_cnt;
  logic crash_sel;
  logic outputs_ok;
  logic [oamc_pkg::TMR_W-1:0] ds_cnt [2];

  oamc_pin_filter #(
    .FILT_CYC(EN_FILT_CYC)
  ) u_en_filt (
    .clk(clk),
    .rst_n(rst_n),
    .pin(en_out_pin),
    .level(en_level),
    .rise(en_rise)
  );

  // Chip select synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      csn_s1 <= 1'b1;
      csn_s2 <= 1'b1;
    end else begin
      csn_s1 <= csn_pin;
      csn_s2 <= csn_s1;
    end
  end

  // Frequency decode, saturating above the top step
  always_comb begin
    if (pwm_freq_sel >= oamc_pkg::FREQ_MAX_CODE) begin
      freq_khz = 5'(oamc_pkg::FREQ_MAX_KHZ);
    end else begin
      freq_khz = 5'(oamc_pkg::FREQ_BASE_KHZ) +
        5'(pwm_freq_sel) * 5'(oamc_pkg::FREQ_STEP_KHZ);
    end
  end

  assign crash_sel = (crash_override_sel == oamc_pkg::CRASH_ON);
  assign pump_ok = supply.pump_above_low;

  // Mode state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= oamc_pkg::OAMC_STANDBY;
    end else if (!supply.io_above_sleep || !supply.core_above_rst) begin
      mode <= oamc_pkg::OAMC_SLEEP;
    end else begin
      unique case (mode)
        oamc_pkg::OAMC_SLEEP: begin
          mode <= oamc_pkg::OAMC_STANDBY;
        end
        oamc_pkg::OAMC_STANDBY: begin
          if (!csn_s2) begin
            mode <= oamc_pkg::OAMC_NORMAL;
          end
        end
        oamc_pkg::OAMC_NORMAL: begin
          if (!supply.io_above_uv) begin
            mode <= oamc_pkg::OAMC_STANDBY;
          end else if (crash_sel) begin
            mode <= oamc_pkg::OAMC_CRASH;
          end else if (standby_req_a && standby_req_b &&
                       act_state == oamc_pkg::OAMC_IDLE && out_on == 6'h00)
          begin
            mode <= oamc_pkg::OAMC_STANDBY;
          end
        end
        oamc_pkg::OAMC_CRASH: begin
          if (!supply.io_above_uv) begin
            mode <= oamc_pkg::OAMC_STANDBY;
          end else if (!crash_sel) begin
            mode <= oamc_pkg::OAMC_NORMAL;
          end
        end
      endcase
    end
  end

  // Configuration reset while asleep or in standby; wake signalled on SDO
  assign cfg_reset = (mode == oamc_pkg::OAMC_SLEEP) ||
                     (mode == oamc_pkg::OAMC_STANDBY);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_low <= 1'b0;
    end else begin
      sdo_low <= (mode == oamc_pkg::OAMC_NORMAL ||
                  mode == oamc_pkg::OAMC_CRASH) &&
                 supply.supplies_stable;
    end
  end

  // Sticky pump-low flag, set wins over clear, default again in sleep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_low_flag <= 1'b1;
    end else if (mode == oamc_pkg::OAMC_SLEEP) begin
      pump_low_flag <= 1'b1;
    end else if (!pump_ok) begin
      pump_low_flag <= 1'b1;
    end else if (pump_low_clr) begin
      pump_low_flag <= 1'b0;
    end
  end

  assign outputs_ok = en_level && pump_ok &&
                      (mode == oamc_pkg::OAMC_NORMAL ||
                       mode == oamc_pkg::OAMC_CRASH);
  assign act_start = (en_rise || start_cmd) && outputs_ok &&
                     act_state == oamc_pkg::OAMC_IDLE;
  // Drain-source faults only reported, never stopping, while in crash override
  assign act_abort = !en_level ||
                     (global_fault && mode != oamc_pkg::OAMC_CRASH) ||
                     (mode == oamc_pkg::OAMC_NORMAL && crash_sel);

  // Timed actuation sequencer: on phase then grounded off phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_state <= oamc_pkg::OAMC_IDLE;
      act_cnt <= '0;
    end else begin
      unique case (act_state)
        oamc_pkg::OAMC_IDLE: begin
          if (act_start) begin
            act_state <= oamc_pkg::OAMC_ON;
            act_cnt <= on_time_cyc;
          end
        end
        oamc_pkg::OAMC_ON: begin
          if (act_abort) begin
            act_state <= oamc_pkg::OAMC_IDLE;
          end else if (act_cnt <= 1) begin
            act_state <= oamc_pkg::OAMC_OFF;
            act_cnt <= off_time_cyc;
          end else begin
            act_cnt <= act_cnt - 1'b1;
          end
        end
        oamc_pkg::OAMC_OFF: begin
          if (act_cnt <= 1 || !en_level) begin
            act_state <= oamc_pkg::OAMC_IDLE;
          end else begin
            act_cnt <= act_cnt - 1'b1;
          end
        end
        default: begin
          act_state <= oamc_pkg::OAMC_IDLE;
        end
      endcase
    end
  end

  // Overcurrent latch; held clear in emergency, so outputs retry and overcurrent is not reported
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_latched <= 6'h00;
    end else if (mode == oamc_pkg::OAMC_CRASH) begin
      oc_latched <= 6'h00;
    end else begin
      oc_latched <= oc_latched | oc_det;
    end
  end

  // Grouped outputs: whole group switches off when any member has latched overcurrent
  always_comb begin
    out_on = 6'h00;
    if (act_state == oamc_pkg::OAMC_ON && outputs_ok) begin
      out_on = ~oc_latched;
      if (group_a) begin
        out_on[2:0] = {3{!(|oc_latched[2:0])}};
      end
      if (group_b) begin
        out_on[5:3] = {3{!(|oc_latched[5:3])}};
      end
    end
  end

  // Group targets: summed current, master duty
  assign grp_cur_a = group_a ? 10'(chan[0].cur) + 10'(chan[1].cur) +
                     10'(chan[2].cur) : 10'(chan[0].cur);
  assign grp_cur_b = group_b ? 10'(chan[3].cur) + 10'(chan[4].cur) +
                     10'(chan[5].cur) : 10'(chan[3].cur);
  assign duty_a = chan[0].duty;
  assign duty_b = chan[3].duty;

  assign ds_thresh_act = ds_thresh;

  // Drain-source monitors with delay, latched until software clears
  genvar g;
  generate
    for (g = 0; g < oamc_pkg::N_EXT; g++) begin : g_ds
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ds_cnt[g] <= '0;
          ds_fault[g] <= 1'b0;
        end else begin
          if (ds_over[g] && ext_hs_on[g]) begin
            ds_cnt[g] <= ds_cnt[g] + 1'b1;
          end else begin
            ds_cnt[g] <= '0;
          end
          if (ds_over[g] && ext_hs_on[g] &&
              ds_cnt[g] + 1'b1 >= ds_delay_cyc) begin
            ds_fault[g] <= 1'b1;
          end else if (ds_fault_clr[g]) begin
            ds_fault[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Global fault, ignored for switch-off in emergency
  assign global_fault = (|ds_fault) || (|oc_latched);
  assign fault_pin = fault_pin_sel & global_fault;

  // External bridge: high side in on phase, low side after dead time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dt_cnt <= '0;
    end else if (act_state == oamc_pkg::OAMC_OFF) begin
      if (dt_cnt < DEAD_CYC) begin
        dt_cnt <= dt_cnt + 1'b1;
      end
    end else begin
      dt_cnt <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_hs_on <= 2'b00;
      ext_ls_on <= 2'b00;
    end else begin
      for (int i = 0; i < oamc_pkg::N_EXT; i++) begin
        ext_hs_on[i] <= act_state == oamc_pkg::OAMC_ON && outputs_ok &&
                        (!ds_fault[i] ||
                         mode == oamc_pkg::OAMC_CRASH);
        ext_ls_on[i] <= act_state == oamc_pkg::OAMC_OFF &&
                        dt_cnt >= DEAD_CYC && en_level;
      end
    end
  end

  // Assertions
  sleep_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(mode) == oamc_pkg::OAMC_SLEEP && mode != oamc_pkg::OAMC_SLEEP
    |-> mode == oamc_pkg::OAMC_STANDBY)
    else $error("sleep left to wrong mode");
  en_low_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !en_level |-> out_on == 6'h00)
    else $error("outputs on with enable low");
  pump_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !pump_ok |-> out_on == 6'h00)
    else $error("outputs on with pump low");
  pump_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    pump_low_flag && !pump_low_clr |=> pump_low_flag)
    else $error("pump flag lost");
  ds_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    ds_fault[0] && !ds_fault_clr[0] |=> ds_fault[0])
    else $error("drain-source fault dropped");
  ds_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    ds_fault[0] && mode != oamc_pkg::OAMC_CRASH |=> !ext_hs_on[0])
    else $error("faulted driver still on");
  sleep_pump_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == oamc_pkg::OAMC_SLEEP |=> pump_low_flag)
    else $error("pump flag not back to default");
  fault_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    fault_pin_sel |-> fault_pin == global_fault)
    else $error("fault pin mismatch");
  dead_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ext_ls_on[0]) |-> dt_cnt >= DEAD_CYC)
    else $error("low side before dead time");
  crash_enter_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == oamc_pkg::OAMC_NORMAL && crash_sel && supply.io_above_uv &&
    supply.io_above_sleep && supply.core_above_rst
    |=> mode == oamc_pkg::OAMC_CRASH)
    else $error("emergency not entered");
  act_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
    act_state == oamc_pkg::OAMC_ON && !en_level
    |=> act_state == oamc_pkg::OAMC_IDLE)
    else $error("actuation kept with enable low");
  group_a_a: assert property (@(posedge clk) disable iff (!rst_n)
    group_a |-> out_on[1] == out_on[0] && out_on[2] == out_on[0])
    else $error("group members differ");
  wake_c: cover property (@(posedge clk) disable iff (!rst_n)
    mode == oamc_pkg::OAMC_STANDBY ##1 mode == oamc_pkg::OAMC_NORMAL);
  act_c: cover property (@(posedge clk) disable iff (!rst_n)
    act_state == oamc_pkg::OAMC_ON ##1 act_state == oamc_pkg::OAMC_OFF);
  crash_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode == oamc_pkg::OAMC_NORMAL && crash_sel &&
    act_state == oamc_pkg::OAMC_ON
    |=> act_state == oamc_pkg::OAMC_IDLE)
    else $error("actuation kept on crash entry");
  crash_c: cover property (@(posedge clk) disable iff (!rst_n)
    mode == oamc_pkg::OAMC_CRASH);
  standby_c: cover property (@(posedge clk) disable iff (!rst_n)
    mode == oamc_pkg::OAMC_NORMAL ##1 mode == oamc_pkg::OAMC_STANDBY);
endmodule

// *** sim/oamc_host.sv ***
// Host controller model driving the command lines of the controller
`timescale 1ns/100ps
module oamc_host (
  input wire logic clk,
  output logic csn_pin,
  output logic start_cmd,
  output logic standby_req_a,
  output logic standby_req_b,
  output logic [1:0] crash_override_sel,
  output logic pump_low_clr
);
  // Idle levels of all command lines
  initial begin
    csn_pin = 1'b1;
    start_cmd = 1'b0;
    standby_req_a = 1'b0;
    standby_req_b = 1'b0;
    crash_override_sel = 2'h0;
    pump_low_clr = 1'b0;
  end

  // Command strobe held n cycles, prompt or slow
  task automatic pulse(input int sel, input int n);
    @(negedge clk);
    case (sel)
      0: csn_pin = 1'b0;
      1: start_cmd = 1'b1;
      2: begin
        standby_req_a = 1'b1;
        standby_req_b = 1'b1;
      end
      default: pump_low_clr = 1'b1;
    endcase
    repeat (n) @(negedge clk);
    csn_pin = 1'b1;
    start_cmd = 1'b0;
    standby_req_a = 1'b0;
    standby_req_b = 1'b0;
    pump_low_clr = 1'b0;
  endtask

  // Crash override pattern write
  task automatic crash(input logic [1:0] v);
    @(negedge clk);
    crash_override_sel = v;
  endtask
endmodule

// *** sim/tb.sv ***
// Self-checking bench of the mode and actuation controller
`timescale 1ns/100ps
module tb;
  localparam int FILT = 8;
  localparam int DEAD = 6;
  logic clk, rst_n, en_out_pin, csn_pin, start_cmd, pump_low_clr;
  logic standby_req_a, standby_req_b, fault_pin_sel, group_a, group_b;
  logic [1:0] crash_override_sel, ds_over, ds_fault_clr;
  logic [1:0] ext_hs_on, ext_ls_on, ds_fault;
  logic [2:0] pwm_freq_sel;
  logic [4:0] freq_khz;
  logic [5:0] oc_det, out_on, oc_latched;
  logic [7:0] ds_thresh, ds_thresh_act, duty_a, duty_b;
  logic [9:0] grp_cur_a, grp_cur_b;
  logic [31:0] on_time_cyc, off_time_cyc, ds_delay_cyc;
  logic global_fault, fault_pin, pump_low_flag, sdo_low, cfg_reset;
  oamc_pkg::oamc_supply_t supply;
  oamc_pkg::oamc_chan_t [5:0] chan;
  oamc_pkg::oamc_mode_t mode;
  oamc_pkg::oamc_act_t act_state;
  int error_cnt = 0;
  int cmp_count = 0;
  int n, d;
  int pat[3] = '{1, 3, 0};

  oamc_host oamc_host_inst (.clk(clk), .csn_pin(csn_pin),
    .start_cmd(start_cmd), .standby_req_a(standby_req_a),
    .standby_req_b(standby_req_b), .pump_low_clr(pump_low_clr),
    .crash_override_sel(crash_override_sel));
  oamc_ctrl #(.EN_FILT_CYC(FILT), .DEAD_CYC(DEAD)) oamc_ctrl_inst (
    .clk(clk), .rst_n(rst_n), .en_out_pin(en_out_pin), .csn_pin(csn_pin),
    .supply(supply), .pwm_freq_sel(pwm_freq_sel), .start_cmd(start_cmd),
    .crash_override_sel(crash_override_sel), .standby_req_a(standby_req_a),
    .standby_req_b(standby_req_b), .on_time_cyc(on_time_cyc),
    .off_time_cyc(off_time_cyc), .ds_thresh(ds_thresh),
    .ds_delay_cyc(ds_delay_cyc), .ds_over(ds_over),
    .ds_fault_clr(ds_fault_clr), .oc_det(oc_det),
    .fault_pin_sel(fault_pin_sel), .group_a(group_a), .group_b(group_b),
    .chan(chan), .pump_low_clr(pump_low_clr), .mode(mode),
    .freq_khz(freq_khz), .out_on(out_on), .oc_latched(oc_latched),
    .ext_hs_on(ext_hs_on), .ext_ls_on(ext_ls_on), .ds_fault(ds_fault),
    .global_fault(global_fault), .fault_pin(fault_pin),
    .pump_low_flag(pump_low_flag), .sdo_low(sdo_low),
    .cfg_reset(cfg_reset), .ds_thresh_act(ds_thresh_act),
    .grp_cur_a(grp_cur_a), .grp_cur_b(grp_cur_b), .duty_a(duty_a),
    .duty_b(duty_b), .act_state(act_state));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Counts, verdict and end of run
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Value comparison
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Mode comparison
  task automatic chk_mode(input oamc_pkg::oamc_mode_t e);
    cmp_count++;
    if (mode !== e) begin
      error_cnt++;
      $display("[ERR] mode expected %0d seen %0d", e, mode);
    end
  endtask

  // Bounded wait for a mode and/or sequencer state, -1 is any
  task automatic wait_for(input int m, input int a);
    int k;
    k = 0;
    while (!((m < 0 || mode === m) && (a < 0 || act_state === a))) begin
      if (k == 300) begin
        error_cnt++;
        $display("[ERR] wait expected %0d %0d seen timeout", m, a);
        stop_test();
      end
      @(negedge clk);
      k++;
    end
  endtask

  // Cycles spent in a state, optionally until low side turns on
  task automatic count(input int a, input logic ls, output int c);
    c = 0;
    while (act_state === a && !(ls && ext_ls_on !== 2'h0) && c < 999) begin
      @(negedge clk);
      c++;
    end
    if (c == 999) begin
      error_cnt++;
      $display("[ERR] count expected end seen timeout");
      stop_test();
    end
  endtask

  // Reference group current: sum of member targets
  function automatic int model_sum(input int b);
    int s;
    s = 0;
    for (int i = b; i < b + 3; i++) begin
      s += chan[i].cur;
    end
    return s;
  endfunction

  // One full timed actuation measured against its settings
  task automatic act_check();
    wait_for(-1, 1);
    @(negedge clk);
    chk("hs_on", 1, |ext_hs_on);
    count(1, 1'b0, n);
    chk("on_len", on_time_cyc, n + 1);
    chk("out_off", 0, out_on);
    count(2, 1'b1, d);
    // High side drops one cycle into the off phase
    chk("dead", DEAD, d - 1);
    chk("ls_on", 1, |ext_ls_on);
    count(2, 1'b0, n);
    chk("off_len", off_time_cyc, d + n);
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h50b1_3e88));
    rst_n = 1'b0;
    en_out_pin = 1'b0;
    supply = 5'h1f;
    pwm_freq_sel = 3'h0;
    on_time_cyc = 32'h0000_0010;
    off_time_cyc = 32'h0000_0010;
    ds_thresh = 8'($urandom);
    ds_delay_cyc = 32'h0000_0005;
    ds_over = 2'h0;
    ds_fault_clr = 2'h0;
    oc_det = 6'h00;
    fault_pin_sel = 1'b1;
    group_a = 1'b1;
    group_b = 1'b1;
    chan = '0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    chk_mode(oamc_pkg::OAMC_STANDBY);
    chk("pump_flag", 1, pump_low_flag);
    chk("cfg_rst", 1, cfg_reset);
    for (int c = 0; c < 8; c++) begin
      pwm_freq_sel = 3'(c);
      @(negedge clk);
      chk("freq", (c < 7) ? 10 + 2 * c : 24, freq_khz);
    end
    $display("test reset and frequency done");
    supply.supplies_stable = 1'b0;
    oamc_host_inst.pulse(0, 2);
    wait_for(2, -1);
    repeat (3) @(negedge clk);
    chk("sdo_wait", 0, sdo_low);
    supply.supplies_stable = 1'b1;
    @(negedge clk);
    chk("sdo_low", 1, sdo_low);
    chk("cfg_run", 0, cfg_reset);
    chk("thresh", ds_thresh, ds_thresh_act);
    for (int r = 0; r < 4; r++) begin
      chan = 102'({$urandom, $urandom, $urandom, $urandom});
      for (int i = 0; i < 6; i++) begin
        chan[i].cur_mode = r[0];
      end
      @(negedge clk);
      if (r[0]) begin
        chk("grp_a", model_sum(0), grp_cur_a);
        chk("grp_b", model_sum(3), grp_cur_b);
      end else begin
        chk("duty_a", chan[0].duty, duty_a);
        chk("duty_b", chan[3].duty, duty_b);
      end
    end
    $display("test wake and groups done");
    supply.pump_above_low = 1'b0;
    en_out_pin = 1'b1;
    oamc_host_inst.pulse(3, 1);
    repeat (FILT + 2) @(negedge clk);
    oamc_host_inst.pulse(1, 1);
    chk("pump_flag", 1, pump_low_flag);
    chk("no_start", 0, act_state);
    en_out_pin = 1'b0;
    supply.pump_above_low = 1'b1;
    oamc_host_inst.pulse(3, 1);
    chk("pump_clr", 0, pump_low_flag);
    for (int i = 0; i < 2; i++) begin
      on_time_cyc = 32'(4 + $urandom % 8);
      off_time_cyc = 32'(DEAD + 2 + $urandom % 8);
      if (i == 0) begin
        en_out_pin = 1'b1;
        repeat (FILT - 3) @(negedge clk);
        en_out_pin = 1'b0;
        repeat (4) @(negedge clk);
        chk("glitch", 0, act_state);
        en_out_pin = 1'b1;
      end else begin
        oamc_host_inst.pulse(1, 1);
      end
      act_check();
    end
    oamc_host_inst.pulse(1, 1);
    oamc_host_inst.pulse(1, 1);
    chk("restart", 1, act_state);
    en_out_pin = 1'b0;
    repeat (4) @(negedge clk);
    chk("abort", 0, act_state);
    chk("out_off", 0, out_on);
    oamc_host_inst.pulse(1, 1);
    chk("en_low", 0, act_state);
    $display("test actuation done");
    en_out_pin = 1'b1;
    wait_for(-1, 1);
    oamc_host_inst.pulse(2, 1);
    chk_mode(oamc_pkg::OAMC_NORMAL);
    en_out_pin = 1'b0;
    wait_for(-1, 0);
    oamc_host_inst.pulse(2, 1);
    chk_mode(oamc_pkg::OAMC_STANDBY);
    oamc_host_inst.pulse(0, 2);
    wait_for(2, -1);
    supply.io_above_uv = 1'b0;
    wait_for(1, -1);
    chk_mode(oamc_pkg::OAMC_STANDBY);
    supply.io_above_uv = 1'b1;
    supply.io_above_sleep = 1'b0;
    wait_for(0, -1);
    chk_mode(oamc_pkg::OAMC_SLEEP);
    supply.io_above_sleep = 1'b1;
    @(negedge clk);
    chk_mode(oamc_pkg::OAMC_STANDBY);
    chk("pump_rst", 1, pump_low_flag);
    $display("test modes done");
    oamc_host_inst.pulse(0, 2);
    wait_for(2, -1);
    oamc_host_inst.pulse(3, 1);
    on_time_cyc = 32'h0000_0010;
    ds_over = 2'b01;
    en_out_pin = 1'b1;
    wait_for(-1, 1);
    wait_for(-1, 0);
    chk("ds_flt", 2'b01, ds_fault);
    chk("glb_flt", 1, global_fault);
    chk("pin_on", 1, fault_pin);
    fault_pin_sel = 1'b0;
    ds_over = 2'b00;
    @(negedge clk);
    chk("pin_off", 0, fault_pin);
    chk("ds_hold", 2'b01, ds_fault);
    ds_fault_clr = 2'b01;
    @(negedge clk);
    ds_fault_clr = 2'b00;
    chk("ds_clr", 0, ds_fault);
    $display("test drain monitor done");
    foreach (pat[i]) begin
      oamc_host_inst.crash(2'(pat[i]));
      @(negedge clk);
      chk_mode(oamc_pkg::OAMC_NORMAL);
    end
    oamc_host_inst.pulse(1, 1);
    oamc_host_inst.crash(2'b10);
    repeat (2) @(negedge clk);
    chk_mode(oamc_pkg::OAMC_CRASH);
    chk("crash_abort", 0, act_state);
    oc_det = 6'h3f;
    oamc_host_inst.pulse(1, 1);
    repeat (3) @(negedge clk);
    chk("crash_run", 1, act_state);
    chk("oc_retry", 0, oc_latched);
    $display("test emergency done");
    stop_test();
  end
endmodule
